// File: design/aas_amp_sync.sv
// synchronisation event picker for one amplifier
// assumes pwm events are already synchronised levels and div8 is a one-cycle pulse
`timescale 1ns/1ps
module aas_amp_sync
    import aas_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // event sources
    input wire logic div8Pulse,
    input wire logic [2:0] pwmEvt,
    // configuration
    input wire logic enable,
    input wire aas_pkg::aas_src_t source,
    // one pulse per amplification
    output logic syncEvt
);
    typedef struct packed {
        logic [2:0] pwmPrev;
        logic evt;
    } aas_amp_t;
    aas_amp_t s;
    aas_amp_t next_s;
    logic [2:0] rise;

    // rising edges of the pwm sync events; source picks one or the divider
    always_comb
    begin
        next_s = s;
        rise = pwmEvt & ~s.pwmPrev;
        next_s.pwmPrev = pwmEvt;
        case (source)
            SRC_DIV8: next_s.evt = enable & div8Pulse;
            SRC_PWM0: next_s.evt = enable & rise[0];
            SRC_PWM1: next_s.evt = enable & rise[1];
            default: next_s.evt = enable & rise[2];
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    assign syncEvt = s.evt;

    // amplification follows each chosen event one cycle later
    div8_evt_a: assert property (@(posedge clk) disable iff (!rstn)
        enable && source == SRC_DIV8 && div8Pulse |=> syncEvt)
        else $error("divided clock event did not reach amplifier");
    pwm_evt_a: assert property (@(posedge clk) disable iff (!rstn)
        syncEvt |-> $past(enable) && ($past(source) != SRC_DIV8 || $past(div8Pulse)))
        else $error("amplifier event without enabled source");
endmodule

// File: design/aas_pin_sync.sv
// two-flop synchroniser for pins and signals from other domains
// assumes the reset is already released synchronously to clk
`timescale 1ns/1ps
module aas_pin_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // asynchronous in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } aas_sync_t;
    aas_sync_t s;
    aas_sync_t next_s;

    // first stage feeds only the second
    always_comb
    begin
        next_s = s;
        next_s.meta = d;
        next_s.stable = s.meta;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    assign q = s.stable;
endmodule

// File: design/aas_pkg.sv
// constants, register offsets and state types of the amplified conversion control
// assumes a 200 MHz system clock and a 32-bit avalon-mm register port
package aas_pkg;
    // timing
    localparam int CLK_MHZ = 200;
    localparam int AMP_SYNC_MAX_KHZ = 250;
    localparam int PRESCALE_DEF = 8;
    localparam int PRE_W = 7;
    localparam int SYNC_DIV = 8;
    localparam logic [2:0] PHASE_LAST = 3'h7;
    localparam logic [3:0] CONV_TICKS = 4'hd;
    localparam logic [3:0] CONV_TICKS_SYNC = 4'he;
    localparam logic [3:0] SAMPLE_TICKS = 4'h2;
    // register byte offsets
    localparam logic [5:0] OFS_CTRL_A = 6'h00;
    localparam logic [5:0] OFS_CTRL_B = 6'h04;
    localparam logic [5:0] OFS_MUX = 6'h08;
    localparam logic [5:0] OFS_RES_HI = 6'h0c;
    localparam logic [5:0] OFS_RES_LO = 6'h10;
    localparam logic [5:0] OFS_PIN_OFF0 = 6'h14;
    localparam logic [5:0] OFS_PIN_OFF1 = 6'h18;
    localparam logic [5:0] OFS_AMP0 = 6'h1c;
    localparam logic [5:0] OFS_AMP1 = 6'h20;
    localparam logic [5:0] OFS_PORT_IN = 6'h24;
    // field positions
    localparam int CA_START = 6;
    localparam int CA_AUTO = 5;
    localparam int CA_BUSY = 0;
    localparam int MUX_LEFT = 5;
    localparam int AMP_EN = 7;
    localparam int AMP_SHUNT = 6;
    localparam int AMP_GAIN = 4;
    localparam int AMP_SRC = 0;
    localparam logic [7:0] AMP_MASK = 8'hf3;
    localparam logic [5:0] PIN_OFF1_MASK = 6'h3f;
    localparam int PIN_N = 14;
    // channel and trigger codes
    localparam logic [3:0] CH_AMP0 = 4'hd;
    localparam logic [3:0] CH_AMP1 = 4'he;
    localparam logic [3:0] TRIG_PWM0 = 4'h8;
    localparam logic [3:0] TRIG_PWM2 = 4'ha;
    // sync source and gain encodings
    typedef enum logic [1:0] {SRC_DIV8 = 2'h0, SRC_PWM0 = 2'h1, SRC_PWM1 = 2'h2,
        SRC_PWM2 = 2'h3} aas_src_t;
    typedef enum logic [1:0] {GAIN_5 = 2'h0, GAIN_10 = 2'h1, GAIN_20 = 2'h2,
        GAIN_40 = 2'h3} aas_gain_t;
    // conversion sequencer, gray coded along idle-armed-run-hold
    typedef enum logic [1:0] {ST_IDLE = 2'h0, ST_ARMED = 2'h1, ST_RUN = 2'h3,
        ST_HOLD = 2'h2} aas_state_t;
endpackage

// File: design/aas_top.sv
// amplified conversion control: registers, pin input gating, sync and sequencing
// assumes an avalon-mm master on clk, converter data on clk, analog status via pins
`timescale 1ns/1ps
module aas_top
    import aas_pkg::*;
#(
    parameter int PRESCALE = PRESCALE_DEF
) (
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // avalon-mm slave
    input wire logic [5:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // analog side
    input wire logic [9:0] convData,
    input wire logic ampChange,
    input wire logic [PIN_N-1:0] pinRaw,
    input wire logic [2:0] pwmEvt,
    output logic [PIN_N-1:0] pinBufOff,
    output logic [1:0] ampEnable,
    output logic [1:0] ampShunt,
    output logic [3:0] ampGain,
    output logic [1:0] ampStrobe,
    output logic sampleHold,
    output logic convBusy
);
    typedef struct packed {
        logic waitreq;
        logic [31:0] rdata;
        logic start;
        logic autoEn;
        logic [3:0] trigSrc;
        logic leftAdj;
        logic [3:0] chan;
        logic [7:0] resHi;
        logic [7:0] resLo;
        logic [7:0] off0;
        logic [5:0] off1;
        logic [7:0] amp0;
        logic [7:0] amp1;
        logic [1:0] enEff;
        logic [PRE_W-1:0] preCnt;
        logic tick;
        logic [2:0] phase;
        logic div8;
        aas_state_t st;
        logic ampConv;
        logic ampSel;
        logic [3:0] tickCnt;
        logic [3:0] convLen;
        logic trigPend;
        logic [2:0] pwmPrev;
        logic [1:0] strobe;
        logic sh;
        logic done;
    } aas_top_t;
    aas_top_t s;
    aas_top_t next_s;
    logic [1:0] rstPipe;
    logic rstn;
    logic [PIN_N+3:0] synced;
    logic [PIN_N-1:0] pinIn;
    logic ampChg;
    logic [2:0] pwmSync;
    logic [1:0] syncEvt;
    logic isAmp;
    logic phaseHigh;
    logic pwmTrig;
    logic trigEvt;
    logic selSync;
    logic inSample;
    logic wr;
    logic [31:0] rd;

    // reset released through two flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            rstPipe <= 2'h0;
        else
            rstPipe <= {rstPipe[0], 1'b1};
    end
    assign rstn = rstPipe[1];

    aas_pin_sync #(.W(PIN_N + 4)) u_sync (
        .clk(clk),
        .rstn(rstn),
        .d({pwmEvt, ampChange, pinRaw}),
        .q(synced)
    );
    assign pinIn = synced[PIN_N-1:0];
    assign ampChg = synced[PIN_N];
    assign pwmSync = synced[PIN_N+3:PIN_N+1];

    aas_amp_sync u_amp0 (
        .clk(clk),
        .rstn(rstn),
        .div8Pulse(s.div8),
        .pwmEvt(pwmSync),
        .enable(s.enEff[0]),
        .source(aas_src_t'(s.amp0[AMP_SRC+:2])),
        .syncEvt(syncEvt[0])
    );
    aas_amp_sync u_amp1 (
        .clk(clk),
        .rstn(rstn),
        .div8Pulse(s.div8),
        .pwmEvt(pwmSync),
        .enable(s.enEff[1]),
        .source(aas_src_t'(s.amp1[AMP_SRC+:2])),
        .syncEvt(syncEvt[1])
    );

    // decode helpers
    always_comb
    begin
        wr = write & ~s.waitreq;
        isAmp = (s.chan == CH_AMP0) || (s.chan == CH_AMP1);
        phaseHigh = s.phase[2];
        pwmTrig = s.autoEn && s.trigSrc >= TRIG_PWM0 && s.trigSrc <= TRIG_PWM2;
        trigEvt = pwmTrig && pwmSync[s.trigSrc[1:0]] && !s.pwmPrev[s.trigSrc[1:0]];
        selSync = syncEvt[s.chan == CH_AMP1];
        inSample = s.tickCnt >= s.convLen - CONV_TICKS
            && s.tickCnt < s.convLen - CONV_TICKS + SAMPLE_TICKS;
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rd = 32'h0;
        if (address == OFS_CTRL_A)
            rd = {25'h0, s.start, s.autoEn, 4'h0, s.st != ST_IDLE};
        else if (address == OFS_CTRL_B)
            rd = {28'h0, s.trigSrc};
        else if (address == OFS_MUX)
            rd = {26'h0, s.leftAdj, 1'b0, s.chan};
        else if (address == OFS_RES_HI)
            rd = {24'h0, s.resHi};
        else if (address == OFS_RES_LO)
            rd = {24'h0, s.resLo};
        else if (address == OFS_PIN_OFF0)
            rd = {24'h0, s.off0};
        else if (address == OFS_PIN_OFF1)
            rd = {26'h0, s.off1};
        else if (address == OFS_AMP0)
            rd = {24'h0, s.amp0};
        else if (address == OFS_AMP1)
            rd = {24'h0, s.amp1};
        else if (address == OFS_PORT_IN)
            rd = {18'h0, pinIn & ~{s.off1, s.off0}};
    end

    // next state of everything
    always_comb
    begin
        next_s = s;
        // bus: one wait cycle, then a one-cycle answer with data ready
        next_s.waitreq = !((read | write) && s.waitreq);
        if ((read | write) && s.waitreq)
            next_s.rdata = rd;
        // converter clock prescaler and divide-by-8 phase
        next_s.tick = 1'b0;
        next_s.div8 = 1'b0;
        next_s.preCnt = s.preCnt + PRE_W'(1);
        if (s.preCnt == PRE_W'(PRESCALE - 1))
        begin
            next_s.preCnt = '0;
            next_s.tick = 1'b1;
        end
        if (s.tick)
        begin
            next_s.phase = s.phase + 3'h1;
            next_s.div8 = (s.phase == PHASE_LAST);
        end
        next_s.strobe = syncEvt;
        next_s.pwmPrev = pwmSync;
        next_s.sh = 1'b0;
        next_s.done = 1'b0;
        // register writes
        if (wr && address == OFS_CTRL_A)
        begin
            next_s.autoEn = writedata[CA_AUTO];
            if (writedata[CA_START] && s.st == ST_IDLE)
                next_s.start = 1'b1;
        end
        if (wr && address == OFS_CTRL_B)
            next_s.trigSrc = writedata[3:0];
        if (wr && address == OFS_MUX)
        begin
            next_s.leftAdj = writedata[MUX_LEFT];
            if (s.st == ST_IDLE)
                next_s.chan = writedata[3:0];
        end
        if (wr && address == OFS_PIN_OFF0)
            next_s.off0 = writedata[7:0];
        if (wr && address == OFS_PIN_OFF1)
            next_s.off1 = writedata[5:0] & PIN_OFF1_MASK;
        if (wr && address == OFS_AMP0)
            next_s.amp0 = writedata[7:0] & AMP_MASK;
        if (wr && address == OFS_AMP1)
            next_s.amp1 = writedata[7:0] & AMP_MASK;
        // enable clear is held off while that amplifier converts
        next_s.enEff[0] = next_s.amp0[AMP_EN]
            || (s.enEff[0] && s.st != ST_IDLE && s.ampConv && !s.ampSel);
        next_s.enEff[1] = next_s.amp1[AMP_EN]
            || (s.enEff[1] && s.st != ST_IDLE && s.ampConv && s.ampSel);
        // newest trigger kept; a fresh event beats the consume
        if (s.st == ST_ARMED && selSync)
            next_s.trigPend = 1'b0;
        if (trigEvt)
            next_s.trigPend = 1'b1;
        // sequencer
        case (s.st)
            ST_IDLE:
            begin
                if (s.start && isAmp && pwmTrig)
                    next_s.st = ST_ARMED;
                else if (s.start)
                begin
                    next_s.st = ST_RUN;
                    next_s.tickCnt = 4'h0;
                    next_s.ampConv = isAmp;
                    next_s.ampSel = (s.chan == CH_AMP1);
                    next_s.convLen = (isAmp && phaseHigh) ? CONV_TICKS_SYNC : CONV_TICKS;
                end
            end
            ST_ARMED:
            begin
                if (s.trigPend && selSync)
                begin
                    next_s.st = ST_RUN;
                    next_s.tickCnt = 4'h0;
                    next_s.ampConv = 1'b1;
                    next_s.ampSel = (s.chan == CH_AMP1);
                    next_s.convLen = CONV_TICKS;
                end
            end
            ST_RUN:
            begin
                if (s.ampConv && inSample && ampChg)
                begin
                    next_s.st = ST_HOLD;
                    next_s.tickCnt = 4'h0;
                end
                else if (s.tick)
                begin
                    next_s.tickCnt = s.tickCnt + 4'h1;
                    next_s.sh = (s.tickCnt == s.convLen - CONV_TICKS);
                    if (s.tickCnt == s.convLen - 4'h1)
                    begin
                        next_s.st = ST_IDLE;
                        next_s.start = 1'b0;
                        next_s.done = 1'b1;
                        if (s.leftAdj)
                        begin
                            next_s.resHi = convData[9:2];
                            next_s.resLo = {convData[1:0], 6'h0};
                        end
                        else
                        begin
                            next_s.resHi = {6'h0, convData[9:8]};
                            next_s.resLo = convData[7:0];
                        end
                    end
                end
            end
            default:
            begin
                if (!ampChg)
                begin
                    next_s.st = ST_RUN;
                    next_s.convLen = CONV_TICKS;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s <= '{waitreq: 1'b1, st: ST_IDLE, default: '0};
        else
            s <= next_s;
    end

    // outputs straight from state flops, except convBusy decoded from s.st
    assign readdata = s.rdata;
    assign waitrequest = s.waitreq;
    assign pinBufOff = {s.off1, s.off0};
    assign ampEnable = s.enEff;
    assign ampShunt = {s.amp1[AMP_SHUNT], s.amp0[AMP_SHUNT]};
    assign ampGain = {s.amp1[AMP_GAIN+:2], s.amp0[AMP_GAIN+:2]};
    assign ampStrobe = s.strobe;
    assign sampleHold = s.sh;
    assign convBusy = s.st != ST_IDLE;

    // helper: converter ticks seen since the last (re)start
    logic [4:0] ticksSeen;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ticksSeen <= 5'h0;
        else if (s.st != ST_RUN)
            ticksSeen <= 5'h0;
        else if (s.tick)
            ticksSeen <= ticksSeen + 5'h1;
    end

    sequence wr_en_clear_s;
        wr && address == OFS_AMP0 && !writedata[AMP_EN];
    endsequence
    sequence amp0_busy_s;
        s.st == ST_RUN && s.ampConv && !s.ampSel && s.enEff[0];
    endsequence

    bus_answer_a: assert property (@(posedge clk) disable iff (!rstn)
        (read | write) && waitrequest |=> !waitrequest ##1 waitrequest)
        else $error("bus answer not one cycle");
    left_adjust_a: assert property (@(posedge clk) disable iff (!rstn)
        s.done && s.leftAdj |-> s.resLo[5:0] == 6'h0 && s.resHi == $past(convData[9:2]))
        else $error("left adjusted result misplaced");
    pin_off_a: assert property (@(posedge clk) disable iff (!rstn)
        wr && address == OFS_PIN_OFF0 |=> pinBufOff[7:0] == $past(writedata[7:0]))
        else $error("pin buffer disable not applied");
    pin_mask_a: assert property (@(posedge clk) disable iff (!rstn)
        (read && waitrequest && address == OFS_PORT_IN) |=>
        (readdata[PIN_N-1:0] & pinBufOff) == '0)
        else $error("disabled pin read nonzero");
    conv_len_a: assert property (@(posedge clk) disable iff (!rstn)
        s.st == ST_IDLE && s.start && !(isAmp && pwmTrig) |=>
        s.convLen == ((isAmp && $past(phaseHigh)) ? CONV_TICKS_SYNC : CONV_TICKS))
        else $error("conversion length wrong for phase");
    conv_ticks_a: assert property (@(posedge clk) disable iff (!rstn)
        s.done |-> $past(ticksSeen) + 5'h1 == {1'b0, $past(s.convLen)})
        else $error("conversion tick count wrong");
    other_chan_a: assert property (@(posedge clk) disable iff (!rstn)
        convBusy && wr && address == OFS_MUX |=> s.chan == $past(s.chan))
        else $error("channel changed during conversion");
    abort_restart_a: assert property (@(posedge clk) disable iff (!rstn)
        s.st == ST_RUN && s.ampConv && inSample && ampChg |=>
        s.st == ST_HOLD && s.tickCnt == 4'h0)
        else $error("conversion not aborted on amplifier change");
    auto_start_a: assert property (@(posedge clk) disable iff (!rstn)
        s.st == ST_ARMED && s.trigPend && selSync |=> s.st == ST_RUN ##1 s.tickCnt <= 4'h1)
        else $error("armed conversion did not start at sync");
    en_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_en_clear_s and amp0_busy_s |=> ampEnable[0])
        else $error("enable cleared before conversion end");
    no_rerun_a: assert property (@(posedge clk) disable iff (!rstn)
        s.done |-> !s.start ##1 s.st == ST_IDLE)
        else $error("conversion restarted without start bit");
endmodule

// File: test/aas_far_model.sv
// far side of the converter: result word, amplifier status, pin levels, pwm sync events
// assumes the bench gives commands on clk and waits out the event spacing itself
`timescale 1ns/1ps
module aas_far_model #(
    parameter int MIN_GAP = 800
) (
    // clock
    input wire logic clk,
    // commands from the bench
    input wire logic [9:0] dataSet,
    input wire logic [13:0] pinSet,
    input wire logic changeReq,
    input wire logic [2:0] pulseReq,
    // toward the design
    output logic [9:0] convData,
    output logic ampChange,
    output logic [13:0] pinRaw,
    output logic [2:0] pwmEvt
);
    int gap = MIN_GAP;

    initial pwmEvt = 3'h0;
    // same clock as the core, so pwm events are synchronous to it
    assign convData = dataSet;
    assign pinRaw = pinSet;
    assign ampChange = changeReq;

    // three-cycle event highs, spaced so sync stays at 250kHz and below clk/4
    always @(posedge clk)
    begin
        gap <= (gap < MIN_GAP) ? gap + 1 : gap;
        if (pulseReq != 3'h0 && gap >= MIN_GAP)
        begin
            pwmEvt <= pulseReq;
            gap <= 0;
        end
        else if (gap >= 2)
            pwmEvt <= 3'h0;
    end
endmodule

// File: test/aas_top_bench.sv
// self-checking bench of the amplified conversion control
// assumes a 200 MHz clock and a short converter prescale for run time
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module aas_top_bench;
    import aas_pkg::*;
    localparam int P = 2;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [5:0] address = 6'h00;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic waitrequest;
    logic [9:0] convData, dataSet = 10'h0;
    logic [13:0] pinRaw, pinSet = 14'h0, off;
    logic [2:0] pwmEvt, pulseReq = 3'h0;
    logic ampChange, changeReq = 1'b0;
    logic [13:0] pinBufOff;
    logic [1:0] ampEnable, ampShunt, ampStrobe;
    logic [3:0] ampGain;
    logic sampleHold, convBusy;
    logic [31:0] v;
    logic [5:0] regs [7] = '{OFS_RES_HI, OFS_RES_LO, OFS_PIN_OFF0, OFS_PIN_OFF1, OFS_AMP0,
        OFS_AMP1, 6'h3c};
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n;
    int holds;

    aas_top #(.PRESCALE(P)) i_dut (.clk(clk), .resetn(resetn), .address(address),
        .read(read), .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .convData(convData), .ampChange(ampChange),
        .pinRaw(pinRaw), .pwmEvt(pwmEvt), .pinBufOff(pinBufOff), .ampEnable(ampEnable),
        .ampShunt(ampShunt), .ampGain(ampGain), .ampStrobe(ampStrobe),
        .sampleHold(sampleHold), .convBusy(convBusy));
    aas_far_model i_far (.clk(clk), .dataSet(dataSet), .pinSet(pinSet),
        .changeReq(changeReq), .pulseReq(pulseReq), .convData(convData),
        .ampChange(ampChange), .pinRaw(pinRaw), .pwmEvt(pwmEvt));

    initial
    begin
        forever #2.5 clk = ~clk;
    end

    // hang guard, far above the expected run length
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            failures++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (failures == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // one avalon access; request held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        // waitrequest is looked at mid-cycle, where it has settled before the edge
        do
        begin
            @(negedge clk);
        end
        while (waitrequest !== 1'b0);
        // the edge that sees waitrequest low completes the access
        @(posedge clk);
        v = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge clk);
    endtask

    // busy cycles and sample-and-hold pulses, looked at mid-cycle; ends on a rising edge
    task automatic wait_idle();
        n = 0;
        holds = 0;
        do
        begin
            @(negedge clk);
            n++;
            holds += int'(sampleHold === 1'b1);
        end
        while (convBusy !== 1'b0);
        @(posedge clk);
    endtask

    function automatic logic [15:0] expect_res(input logic [9:0] d, input logic left);
        return left ? {d, 6'h00} : {6'h00, d};
    endfunction

    // start one conversion, wait for it and check both result bytes
    task automatic conv(input logic [3:0] ch, input logic left, input logic [7:0] ctl);
        logic [9:0] d;
        logic [15:0] e;
        d = 10'($urandom);
        e = expect_res(d, left);
        dataSet <= d;
        bus(1'b1, OFS_MUX, {26'h0, left, 1'b0, ch});
        bus(1'b1, OFS_CTRL_A, {24'h0, ctl});
        wait_idle();
        `CHK(holds, 1)
        bus(1'b0, OFS_RES_HI, 32'h0);
        `CHK(v, {24'h0, e[15:8]})
        bus(1'b0, OFS_RES_LO, 32'h0);
        `CHK(v, {24'h0, e[7:0]})
    endtask

    initial
    begin
        void'($urandom(32'hb26a));
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        repeat (3) @(posedge clk);
        // reset values, then an unmapped place
        foreach (regs[i])
        begin
            bus(1'b0, regs[i], 32'h0);
            `CHK(v, 32'h0)
        end
        // random pin levels against random input-off masks
        repeat (4)
        begin
            off = 14'($urandom);
            pinSet <= 14'($urandom);
            bus(1'b1, OFS_PIN_OFF0, {24'h0, off[7:0]});
            bus(1'b1, OFS_PIN_OFF1, {26'h0, off[13:8]});
            `CHK(pinBufOff, off)
            bus(1'b0, OFS_PORT_IN, 32'h0);
            `CHK(v[13:0], pinSet & ~off)
        end
        // every gain code, read back through the register
        for (int g = 0; g < 4; g++)
        begin
            bus(1'b1, OFS_AMP0, 32'(g << AMP_GAIN) | 32'h4c);
            `CHK(ampGain[1:0], 2'(g))
            `CHK(ampShunt[0], 1'b1)
            bus(1'b0, OFS_AMP0, 32'h0);
            `CHK(v, 32'(g << AMP_GAIN) | 32'h40)
        end
        // divided sync: one strobe every eight converter clocks
        bus(1'b1, OFS_AMP1, 32'h80);
        n = 0;
        repeat (SYNC_DIV * P * 5)
        begin
            @(negedge clk);
            n += int'(ampStrobe[1] === 1'b1);
        end
        @(posedge clk);
        `CHK(n, 5)
        // plain channels, both layouts, back-to-back starts
        repeat (4)
        begin
            conv(4'($urandom % 8), 1'($urandom), 8'h40);
            `CHK(n inside {[13 * P - 2 : 14 * P + 4]}, 1'b1)
        end
        bus(1'b1, OFS_AMP0, 32'h80);
        conv(CH_AMP0, 1'b1, 8'h40);
        `CHK(n inside {[13 * P - 2 : 15 * P + 4]}, 1'b1)
        // amplified run: other channel refused, enable clear deferred
        bus(1'b1, OFS_CTRL_A, 32'h40);
        bus(1'b1, OFS_MUX, 32'h01);
        bus(1'b1, OFS_AMP0, 32'h00);
        `CHK(ampEnable[0], 1'b1)
        wait_idle();
        repeat (2) @(posedge clk);
        `CHK(ampEnable[0], 1'b0)
        bus(1'b0, OFS_MUX, 32'h0);
        `CHK(v[3:0], CH_AMP0)
        // amplifier moving at the sample phase stretches the conversion
        bus(1'b1, OFS_AMP0, 32'h80);
        changeReq <= 1'b1;
        bus(1'b1, OFS_CTRL_A, 32'h40);
        repeat (40) @(posedge clk);
        `CHK(convBusy, 1'b1)
        changeReq <= 1'b0;
        wait_idle();
        // a full 13-tick restart once the amplifier has settled
        `CHK(n inside {[13 * P : 13 * P + 6]}, 1'b1)
        // auto trigger from pwm 0: waits for the event, then no free running
        bus(1'b1, OFS_AMP0, 32'h81);
        bus(1'b1, OFS_CTRL_B, {28'h0, TRIG_PWM0});
        repeat (800) @(posedge clk);
        bus(1'b1, OFS_CTRL_A, 32'h60);
        repeat (60) @(posedge clk);
        `CHK(convBusy, 1'b1)
        pulseReq <= 3'h1;
        @(posedge clk);
        pulseReq <= 3'h0;
        wait_idle();
        `CHK(n < 200, 1'b1)
        bus(1'b0, OFS_CTRL_A, 32'h0);
        `CHK(v[CA_START], 1'b0)
        repeat (100) @(posedge clk);
        `CHK(convBusy, 1'b0)
        // non-pwm trigger source behaves as a plain software start
        bus(1'b1, OFS_CTRL_B, 32'h0);
        conv(CH_AMP0, 1'b0, 8'h60);
        `CHK(n <= 15 * P + 4, 1'b1)
        complete_run();
    end
endmodule
